// File: dv/test_timer8_compare_waveform_modes.sv
`timescale 1ns/1ps
module test_timer8_compare_waveform_modes;
  import timer8_pkg::*;
  logic          mclk, rst_n, force_compare_strobe, count_wr, compare_wr, out_preset_wr;
  logic          out_preset_val, overflow_ack, compare_match_ack, port_out_bit, pin_in;
  logic          compare_pin_direction_bit, pin_out, pin_oe_n, pin_in_sync;
  logic          compare_output_state;
  logic [7:0]    count_wdata, compare_wdata, compare_value;
  timer_ctrl_t   ctrl;
  timer_status_t status;
  int            fail_count, checks_done;

  timer8_compare_waveform dut_u (.mclk, .rst_n, .ctrl, .force_compare_strobe, .count_wr,
    .count_wdata, .compare_wr, .compare_wdata, .out_preset_wr, .out_preset_val, .overflow_ack,
    .compare_match_ack, .port_out_bit, .compare_pin_direction_bit, .pin_in, .pin_out,
    .pin_oe_n, .pin_in_sync, .status, .compare_value, .compare_output_state);

  // Clock
  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end

  task automatic chk(logic [7:0] got, logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(logic got, logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task automatic clk(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic setc(logic [1:0] c, waveform_mode_t w, logic [2:0] s);
    ctrl = '{c, w, s};
  endtask
  task automatic load(logic [7:0] v);
    count_wr = 1;
    count_wdata = v;
    clk(1);
    count_wr = 0;
  endtask
  task automatic preset(logic v);
    out_preset_wr = 1;
    out_preset_val = v;
    clk(1);
    out_preset_wr = 0;
  endtask

  task automatic t_reset();
    chk({5'h00, compare_output_state, status.overflow_flag, status.compare_match_flag}, 8'h00);
    chkb(pin_in_sync, 1); chkb(pin_oe_n, 1);
    preset(1);
    chkb(compare_output_state, 1);
    compare_pin_direction_bit = 1;
    rst_n = 0;
    #1 chkb(compare_output_state, 0);
    chkb(pin_oe_n, 0);
    clk(1);
    rst_n = 1;
    clk(1);
    $display("test reset done");
  endtask

  task automatic t_force();
    logic [1:0] cm [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
    logic       ex [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    port_out_bit = 1;
    preset(1);
    for (int i = 0; i < 4; i++) begin
      ctrl.compare_output_mode = cm[i];
      force_compare_strobe = 1;
      clk(1);
      force_compare_strobe = 0;
      chkb(compare_output_state, ex[i]);
      chkb(pin_out, cm[i] != 2'h0 ? ex[i] : 1'b1);
      clk(1);
    end
    $display("test force done");
  endtask

  task automatic t_normal();
    int prediv [4] = '{8, 64, 256, 1024};
    load(8'hff);
    setc(0, WM_NORMAL, 1);
    clk(1);
    chk(status.count_value, 8'h00); chkb(status.overflow_flag, 1);
    clk(3);
    chkb(status.overflow_flag, 1);
    overflow_ack = 1;
    clk(1);
    overflow_ack = 0;
    chkb(status.overflow_flag, 0);
    load(8'h40);
    clk(2);
    chk(status.count_value, 8'h42);
    for (int s = 2; s < 6; s++) begin
      setc(0, WM_NORMAL, 0);
      load(8'h00);
      setc(0, WM_NORMAL, 3'(s));
      clk(prediv[s - 2] - 1);
      chk(status.count_value, 8'h00);
      clk(1);
      chk(status.count_value, 8'h01);
    end
    $display("test normal done");
  endtask

  task automatic t_clear_match();
    setc(1, WM_CLEAR, 0);
    compare_wr = 1;
    compare_wdata = 8'h03;
    load(8'h00);
    compare_wr = 0;
    compare_match_ack = 1;
    preset(0);
    compare_match_ack = 0;
    chk(compare_value, 8'h03);
    chkb(status.compare_match_flag, 0);
    setc(1, WM_CLEAR, 1);
    clk(4);
    chk(status.count_value, 8'h00); chkb(status.compare_match_flag, 1);
    chkb(compare_output_state, 1);
    compare_match_ack = 1;
    clk(1);
    compare_match_ack = 0;
    clk(3);
    chkb(compare_output_state, 0); chkb(status.compare_match_flag, 1);
    setc(1, WM_CLEAR, 0);
    load(8'h10);
    setc(1, WM_CLEAR, 1);
    clk(240);
    chk(status.count_value, 8'h00); chkb(status.overflow_flag, 1);
    chkb(compare_output_state, 0);
    clk(4);
    chkb(compare_output_state, 1);
    $display("test clear match done");
  endtask

  task automatic t_pwm();
    overflow_ack = 1;
    setc(2, WM_FASTPWM, 0);
    compare_wr = 1;
    compare_wdata = 8'h80;
    load(8'hfe);
    compare_wr = 0;
    overflow_ack = 0;
    preset(0);
    chk(compare_value, 8'h03);
    setc(2, WM_FASTPWM, 1);
    clk(2);
    chk(compare_value, 8'h80); chk(status.count_value, 8'h00);
    chkb(compare_output_state, 1); chkb(status.overflow_flag, 1);
    clk(8'h81);
    chkb(compare_output_state, 0);
    setc(3, WM_FASTPWM, 1);
    clk(9'h100);
    chkb(compare_output_state, 1);
    $display("test pwm done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #200us;
    fail_count++;
    final_report();
  end

  // Main sequence
  initial begin
    {rst_n, force_compare_strobe, count_wr, compare_wr, out_preset_wr, out_preset_val} = '0;
    {overflow_ack, compare_match_ack, port_out_bit, compare_pin_direction_bit} = '0;
    {count_wdata, compare_wdata, ctrl} = '0;
    pin_in = 1;
    fail_count = 0;
    checks_done = 0;
    clk(2);
    rst_n = 1;
    clk(2);
    t_reset();
    t_force();
    t_normal();
    t_clear_match();
    t_pwm();
    final_report();
  end
endmodule

bind timer8_compare_waveform timer8_monitor mon_u (.mclk, .rst_n, .ctrl, .force_compare_strobe,
  .count_wr, .out_preset_wr, .out_preset_val, .overflow_ack, .port_out_bit,
  .compare_pin_direction_bit, .pin_out, .pin_oe_n, .status, .compare_value,
  .compare_output_state);

// File: dv/timer8_monitor.sv
`timescale 1ns/1ps
module timer8_monitor
  import timer8_pkg::*;
(
  // Clock and reset
  input wire logic                    mclk,
  input wire logic                    rst_n,
  // Driven inputs
  input wire timer8_pkg::timer_ctrl_t ctrl,
  input wire logic                    force_compare_strobe,
  input wire logic                    count_wr,
  input wire logic                    out_preset_wr,
  input wire logic                    out_preset_val,
  input wire logic                    overflow_ack,
  input wire logic                    port_out_bit,
  input wire logic                    compare_pin_direction_bit,
  // Watched outputs
  input wire logic                    pin_out,
  input wire logic                    pin_oe_n,
  input wire timer8_pkg::timer_status_t status,
  input wire logic [7:0]              compare_value,
  input wire logic                    compare_output_state
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Short names for watched fields
  wire logic [1:0]     com = ctrl.compare_output_mode;
  wire waveform_mode_t wgm = ctrl.waveform_mode_select;
  wire logic           run = ctrl.clock_select == 3'h1 && !count_wr;
  wire logic [7:0]     cnt = status.count_value;
  wire logic           st  = compare_output_state;

  pin_mux_a: assert property (pin_out == (com != 2'h0 ? st : port_out_bit))
    else $error("pin source wrong");
  pin_dir_a: assert property (pin_oe_n == !compare_pin_direction_bit)
    else $error("pin direction wrong");
  com0_hold_a: assert property (com == 2'h0 && !out_preset_wr |=> $stable(st))
    else $error("state moved with mode zero");
  match_clear_a: assert property (run && wgm == WM_CLEAR && cnt == compare_value
    && !$past(count_wr) |=> cnt == 8'h00 && status.compare_match_flag) else $error("no clear");
  normal_inc_a: assert property (run && wgm == WM_NORMAL
    |=> cnt == 8'($past(cnt) + 8'h01)) else $error("bad increment");
  ovf_set_a: assert property (run && wgm != WM_PCPWM && cnt == 8'hff
    |=> status.overflow_flag) else $error("overflow not set");
  ovf_hold_a: assert property (status.overflow_flag && !overflow_ack
    |=> status.overflow_flag) else $error("overflow lost");
  preset_a: assert property (out_preset_wr |=> st == $past(out_preset_val))
    else $error("preset lost");
  match_toggle_a: assert property (run && wgm == WM_CLEAR && com == 2'h1
    && cnt == compare_value
    && !$past(count_wr) && !out_preset_wr && !force_compare_strobe |=> st != $past(st))
    else $error("no toggle");
  force_a: assert property (force_compare_strobe && !wgm[0] && com == 2'h1 && !out_preset_wr
    |=> st != $past(st)) else $error("force ignored");

  cover property (wgm == WM_CLEAR && status.compare_match_flag);
  cover property (status.overflow_flag && overflow_ack);
  cover property (wgm == WM_FASTPWM && $rose(st));
endmodule

// File: hdl/timer8_cfg.svh
`ifndef TIMER8_CFG_SVH
`define TIMER8_CFG_SVH

// ----------------------------------------
// Counter limits and reset values
// ----------------------------------------
`define CNT_BOTTOM    8'h00
`define CNT_MAX       8'hff
`define CNT_RST       8'h00
`define CMP_RST       8'h00
`define OUT_RST       1'b0

// ----------------------------------------
// Waveform mode codes
// ----------------------------------------
`define WGM_NORMAL    2'h0
`define WGM_PCPWM     2'h1
`define WGM_CLEAR     2'h2
`define WGM_FASTPWM   2'h3

// ----------------------------------------
// Compare output mode codes
// ----------------------------------------
`define COM_NONE      2'h0
`define COM_TOGGLE    2'h1
`define COM_CLEAR     2'h2
`define COM_SET       2'h3

// ----------------------------------------
// Clock select codes and prescale divisor masks
// ----------------------------------------
`define CS_STOP       3'h0
`define CS_DIV1       3'h1
`define CS_DIV8       3'h2
`define CS_DIV64      3'h3
`define CS_DIV256     3'h4
`define CS_DIV1024    3'h5
`define PRE_DIV8      10'h007
`define PRE_DIV64     10'h03f
`define PRE_DIV256    10'h0ff
`define PRE_DIV1024   10'h3ff

`endif

// File: hdl/timer8_compare_waveform.sv
`timescale 1ns/1ps
`include "timer8_cfg.svh"
module timer8_compare_waveform
  import timer8_pkg::*;
(
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  // Control
  input  wire timer8_pkg::timer_ctrl_t  ctrl,
  input  wire logic                     force_compare_strobe,
  // Count and compare writes
  input  wire logic                     count_wr,
  input  wire logic [7:0]               count_wdata,
  input  wire logic                     compare_wr,
  input  wire logic [7:0]               compare_wdata,
  // Output state preset
  input  wire logic                     out_preset_wr,
  input  wire logic                     out_preset_val,
  // Flag acknowledges
  input  wire logic                     overflow_ack,
  input  wire logic                     compare_match_ack,
  // Port pin
  input  wire logic                     port_out_bit,
  input  wire logic                     compare_pin_direction_bit,
  input  wire logic                     pin_in,
  output logic                          pin_out,
  output logic                          pin_oe_n,
  output logic                          pin_in_sync,
  // Status
  output timer8_pkg::timer_status_t     status,
  output logic [7:0]                    compare_value,
  output logic                          compare_output_state
);
  import timer8_pkg::*;

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  logic [9:0] pre_q, pre_d;
  logic [7:0] cnt_q, cnt_d;
  logic [7:0] cmp_q, cmp_d;
  logic [7:0] cmpbuf_q, cmpbuf_d;
  logic       out_q, out_d;
  logic       ovf_q, ovf_d;
  logic       ocf_q, ocf_d;
  logic       blk_q, blk_d;
  logic [1:0] pin_sync_q;

  logic       tick;
  logic       match;
  logic       pwm;
  logic [9:0] pre_mask;
  logic       pre_run;
  logic       at_top;
  logic       hit;
  logic       toggle_off;

  // Prescale divisor mask from clock select
  function automatic logic [9:0] pre_mask_f(input logic [2:0] cs);
    case (cs)
      `CS_DIV8:    pre_mask_f = `PRE_DIV8;
      `CS_DIV64:   pre_mask_f = `PRE_DIV64;
      `CS_DIV256:  pre_mask_f = `PRE_DIV256;
      `CS_DIV1024: pre_mask_f = `PRE_DIV1024;
      default:     pre_mask_f = 10'h000;
    endcase
  endfunction

  // Compare output action on a match or force
  function automatic logic out_action_f(input logic [1:0] com, input logic cur);
    case (com)
      `COM_TOGGLE: out_action_f = ~cur;
      `COM_CLEAR:  out_action_f = 1'b0;
      `COM_SET:    out_action_f = 1'b1;
      default:     out_action_f = cur;
    endcase
  endfunction

  // ----------------------------------------
  // Prescaler and match decode
  // ----------------------------------------
  // Undefined clock select codes stop the timer like code zero
  assign pre_mask   = pre_mask_f(ctrl.clock_select);
  assign pre_run    = (ctrl.clock_select != `CS_STOP) && (ctrl.clock_select <= `CS_DIV1024);
  assign tick       = pre_run && ((pre_q & pre_mask) == pre_mask);
  assign pwm        = ctrl.waveform_mode_select[0];
  assign match      = (cnt_q == cmp_q);
  assign at_top     = (cnt_q == `CNT_MAX);
  // Match event, suppressed on the tick right after a count write
  assign hit        = tick && match && !blk_q;
  // Toggle action refused in phase-correct mode
  assign toggle_off = (ctrl.waveform_mode_select == WM_PCPWM)
                      && (ctrl.compare_output_mode == `COM_TOGGLE);

  // ----------------------------------------
  // Prescale counter
  // ----------------------------------------
  // Held at zero while stopped, so a restart begins a full period
  always_comb begin
    pre_d = pre_run ? pre_q + 10'h001 : 10'h000;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 10'h000;
    end else begin
      pre_q <= pre_d;
    end
  end

  // ----------------------------------------
  // Counter sequence
  // ----------------------------------------
  // Steps per waveform mode only; software write has priority
  always_comb begin
    cnt_d = cnt_q;
    blk_d = blk_q;
    if (tick) begin
      case (ctrl.waveform_mode_select)
        WM_CLEAR: begin
          cnt_d = match ? `CNT_BOTTOM : cnt_q + 8'h01;
        end
        WM_FASTPWM: begin
          cnt_d = cnt_q + 8'h01;
        end
        WM_PCPWM: begin
          cnt_d = cnt_q + 8'h01;
        end
        default: begin
          cnt_d = cnt_q + 8'h01;
        end
      endcase
      blk_d = 1'b0;
    end
    // Software count write, blocks match on next tick
    if (count_wr) begin
      cnt_d = count_wdata;
      blk_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= `CNT_RST;
      blk_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      blk_q <= blk_d;
    end
  end

  // ----------------------------------------
  // Compare value and its buffer
  // ----------------------------------------
  // Direct write outside fast PWM; buffered there
  always_comb begin
    cmp_d    = cmp_q;
    cmpbuf_d = cmpbuf_q;
    if (compare_wr) begin
      if (ctrl.waveform_mode_select == WM_FASTPWM) begin
        cmpbuf_d = compare_wdata;
      end else begin
        cmp_d    = compare_wdata;
        cmpbuf_d = compare_wdata;
      end
    end
    // Buffered value applied at the top of the PWM cycle
    if (tick && at_top && ctrl.waveform_mode_select == WM_FASTPWM) begin
      cmp_d = cmpbuf_q;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_q    <= `CMP_RST;
      cmpbuf_q <= `CMP_RST;
    end else begin
      cmp_q    <= cmp_d;
      cmpbuf_q <= cmpbuf_d;
    end
  end

  // ----------------------------------------
  // Overflow and match flags
  // ----------------------------------------
  // Clears first, so a same-cycle set wins
  always_comb begin
    ovf_d = ovf_q;
    ocf_d = ocf_q;
    if (overflow_ack) begin
      ovf_d = 1'b0;
    end
    if (compare_match_ack) begin
      ocf_d = 1'b0;
    end
    // Wrap from full scale in every mode except phase-correct
    if (tick && at_top && ctrl.waveform_mode_select != WM_PCPWM) begin
      ovf_d = 1'b1;
    end
    if (hit) begin
      ocf_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_q <= 1'b0;
      ocf_q <= 1'b0;
    end else begin
      ovf_q <= ovf_d;
      ocf_q <= ocf_d;
    end
  end

  // ----------------------------------------
  // Compare output state
  // ----------------------------------------
  // Priority: preset over force over match over floor
  always_comb begin
    out_d = out_q;
    // Fast PWM: opposite level at the floor
    if (tick && at_top && ctrl.waveform_mode_select == WM_FASTPWM) begin
      if (ctrl.compare_output_mode == `COM_CLEAR) begin
        out_d = 1'b1;
      end else if (ctrl.compare_output_mode == `COM_SET) begin
        out_d = 1'b0;
      end
    end
    // Action uses mode value current at the match
    if (hit && !toggle_off) begin
      out_d = out_action_f(ctrl.compare_output_mode, out_q);
    end
    // Forced match in non-PWM modes, no flag
    if (force_compare_strobe && !pwm) begin
      out_d = out_action_f(ctrl.compare_output_mode, out_q);
    end
    // Preset of output state before the pin is enabled
    if (out_preset_wr) begin
      out_d = out_preset_val;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= `OUT_RST;
    end else begin
      out_q <= out_d;
    end
  end

  // Pin input synchroniser
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync_q <= 2'b00;
    end else begin
      pin_sync_q <= {pin_sync_q[0], pin_in};
    end
  end

  // ----------------------------------------
  // Outputs and port override
  // ----------------------------------------
  assign pin_out  = (ctrl.compare_output_mode != `COM_NONE) ? out_q : port_out_bit;
  assign pin_oe_n = ~compare_pin_direction_bit;
  assign pin_in_sync          = pin_sync_q[1];
  assign status               = '{overflow_flag: ovf_q, compare_match_flag: ocf_q,
                                  count_value: cnt_q};
  assign compare_value        = cmp_q;
  assign compare_output_state = out_q;

endmodule

// File: hdl/timer8_pkg.sv
package timer8_pkg;

  // Waveform generation modes
  typedef enum logic [1:0] {
    WM_NORMAL  = 2'b00,
    WM_PCPWM   = 2'b01,
    WM_CLEAR   = 2'b10,
    WM_FASTPWM = 2'b11
  } waveform_mode_t;

  // Control bits written by software
  typedef struct packed {
    logic [1:0]     compare_output_mode;
    waveform_mode_t waveform_mode_select;
    logic [2:0]     clock_select;
  } timer_ctrl_t;

  // Status reported back to software
  typedef struct packed {
    logic       overflow_flag;
    logic       compare_match_flag;
    logic [7:0] count_value;
  } timer_status_t;

endpackage
